// *** design/asr_ctrl.sv ***
// Controller that drives a 64K by 1 asynchronous static memory through its pins.
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl
	import asr_pkg::*;
#(
	parameter int READ_CYC  = asr_pkg::ASR_READ_CYC,
	parameter int WRITE_CYC = asr_pkg::ASR_WRITE_CYC
) (
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	input  wire logic                           req_valid_i,
	input  wire logic                           req_write_i,
	input  wire logic [asr_pkg::ASR_ADDR_W-1:0] req_addr_i,
	input  wire logic                           req_data_i,
	output logic                                req_ready_o,
	output logic                                rd_valid_o,
	output logic                                rd_data_o,
	output logic [asr_pkg::ASR_ADDR_W-1:0]      cell_address_o,
	output logic                                select_n_o,
	output logic                                write_strobe_n_o,
	output logic                                data_in_o,
	output logic                                data_in_oe_o,
	input  wire logic                           data_out_i
);
	import asr_pkg::*;

	localparam logic [ASR_CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [ASR_CNT_W-1:0] RD_CNT = ASR_CNT_W'(READ_CYC + 2);
	localparam logic [ASR_CNT_W-1:0] WR_CNT = ASR_CNT_W'(WRITE_CYC);
	localparam logic [ASR_CNT_W-1:0] SU_CNT = ASR_CNT_W'(ASR_SETUP_CYC);
	localparam logic [ASR_CNT_W-1:0] HD_CNT = ASR_CNT_W'(ASR_HOLD_CYC);
	localparam logic [ASR_CNT_W-1:0] FL_CNT = ASR_CNT_W'(ASR_FLOAT_CYC);

	asr_state_t                  state_q;
	asr_state_t                  state_d;
	logic [ASR_CNT_W-1:0]        cnt_q;
	logic [ASR_CNT_W-1:0]        cnt_d;
	logic [ASR_CNT_W-1:0]        pulse_q;
	logic [ASR_CNT_W-1:0]        pulse_d;
	logic [ASR_ADDR_W-1:0]       addr_q;
	logic [ASR_ADDR_W-1:0]       addr_d;
	logic                        sel_n_q;
	logic                        sel_n_d;
	logic                        we_n_q;
	logic                        we_n_d;
	logic                        din_q;
	logic                        din_d;
	logic                        oe_q;
	logic                        oe_d;
	logic                        rvalid_q;
	logic                        rvalid_d;
	logic                        rdata_q;
	logic                        rdata_d;
	logic                        dout_sync;

	// The data output pin is asynchronous to this clock.
	asr_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (data_out_i),
		.q_o   (dout_sync)
	);

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		pulse_d  = pulse_q;
		addr_d   = addr_q;
		sel_n_d  = sel_n_q;
		we_n_d   = we_n_q;
		din_d    = din_q;
		oe_d     = oe_q;
		rvalid_d = 1'b0;
		rdata_d  = rdata_q;
		case (state_q)
			ASR_IDLE: begin
				// Select stays high between requests for standby.
				sel_n_d = 1'b1;
				we_n_d  = 1'b1;
				oe_d    = 1'b0;
				if (req_valid_i) begin
					// Address moves only while the strobe is high.
					addr_d = req_addr_i;
					din_d  = req_data_i;
					if (req_write_i) begin
						state_d = ASR_WSET;
						cnt_d   = SU_CNT;
					end else begin
						state_d = ASR_RSET;
					end
				end
			end
			ASR_RSET: begin
				// Address is stable before select falls, so select access applies.
				sel_n_d = 1'b0;
				we_n_d  = 1'b1;
				cnt_d   = RD_CNT;
				state_d = ASR_RWAIT;
			end
			ASR_RWAIT: begin
				// Wait covers access time plus the two synchroniser stages.
				if (cnt_q == CNT_ONE) begin
					rvalid_d = 1'b1;
					rdata_d  = dout_sync;
					sel_n_d  = 1'b1;
					state_d  = ASR_IDLE;
				end else begin
					cnt_d = cnt_q - CNT_ONE;
				end
			end
			ASR_WSET: begin
				// Strobe falls first, so the output stays floating at select fall.
				// Select waits for the registered strobe to be low, so the two never fall together.
				we_n_d = 1'b0;
				if (cnt_q != CNT_ONE) begin
					cnt_d = cnt_q - CNT_ONE;
				end else if (!we_n_q) begin
					sel_n_d = 1'b0;
					cnt_d   = (WR_CNT > FL_CNT) ? WR_CNT : FL_CNT;
					pulse_d = FL_CNT;
					state_d = ASR_WPULS;
				end
			end
			ASR_WPULS: begin
				// Data drive waits out the float delay to avoid contention on shared wires.
				if (pulse_q == CNT_ONE) begin
					oe_d = 1'b1;
				end else begin
					pulse_d = pulse_q - CNT_ONE;
				end
				// Select held low the full pulse, then its rise ends the write.
				if (cnt_q == CNT_ONE && oe_q) begin
					sel_n_d = 1'b1;
					cnt_d   = HD_CNT;
					state_d = ASR_WHOLD;
				end else if (cnt_q != CNT_ONE) begin
					cnt_d = cnt_q - CNT_ONE;
				end
			end
			ASR_WHOLD: begin
				// Data and address held past the select rise before release.
				if (cnt_q == CNT_ONE) begin
					we_n_d  = 1'b1;
					oe_d    = 1'b0;
					state_d = ASR_IDLE;
				end else begin
					cnt_d = cnt_q - CNT_ONE;
				end
			end
			default: begin
				state_d = ASR_IDLE;
				sel_n_d = 1'b1;
				we_n_d  = 1'b1;
				oe_d    = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q  <= ASR_IDLE;
			cnt_q    <= '0;
			pulse_q  <= '0;
			addr_q   <= '0;
			sel_n_q  <= 1'b1;
			we_n_q   <= 1'b1;
			din_q    <= 1'b0;
			oe_q     <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			pulse_q  <= pulse_d;
			addr_q   <= addr_d;
			sel_n_q  <= sel_n_d;
			we_n_q   <= we_n_d;
			din_q    <= din_d;
			oe_q     <= oe_d;
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
		end
	end

	assign req_ready_o      = (state_q == ASR_IDLE);
	assign rd_valid_o       = rvalid_q;
	assign rd_data_o        = rdata_q;
	assign cell_address_o   = addr_q;
	assign select_n_o       = sel_n_q;
	assign write_strobe_n_o = we_n_q;
	assign data_in_o        = din_q;
	assign data_in_oe_o     = oe_q;
endmodule
`default_nettype wire

// *** design/asr_pkg.sv ***
// Package of pin timing constants and states for the static memory controller.
package asr_pkg;
	localparam int ASR_ADDR_W = 16;
	localparam int ASR_CLK_NS = 50;
	// Slowest speed grade figures, in nanoseconds.
	localparam int ASR_READ_ACCESS_NS = 70;
	localparam int ASR_WRITE_PULSE_NS = 30;
	localparam int ASR_ADDR_SETUP_NS = 7;
	localparam int ASR_ADDR_HOLD_NS = 5;
	localparam int ASR_STROBE_TO_OUTPUT_FLOAT_NS = 30;
	localparam int ASR_SELECT_HIGH_NS = 30;
	// Least times round up to whole cycles, never below one.
	localparam int ASR_READ_CYC = (ASR_READ_ACCESS_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
	localparam int ASR_WRITE_CYC = (ASR_WRITE_PULSE_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
	localparam int ASR_SETUP_CYC = (ASR_ADDR_SETUP_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
	localparam int ASR_HOLD_CYC = (ASR_ADDR_HOLD_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
	localparam int ASR_FLOAT_CYC =
		(ASR_STROBE_TO_OUTPUT_FLOAT_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
	localparam int ASR_CNT_W = 4;
	typedef enum logic [5:0] {
		ASR_IDLE  = 6'h01,
		ASR_RSET  = 6'h02,
		ASR_RWAIT = 6'h04,
		ASR_WSET  = 6'h08,
		ASR_WPULS = 6'h10,
		ASR_WHOLD = 6'h20
	} asr_state_t;
endpackage

// *** design/asr_sync.sv ***
// Two flip-flop synchroniser for the memory data output pin.
`timescale 1ns/1ns
`default_nettype none
module asr_sync (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = d_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q_o = sync_q;
endmodule
`default_nettype wire

// *** verif/asr_ctrl_chk_properties.sv ***
// Pin-level assertions for the static memory controller.
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        req_valid_i,
	input wire logic        req_write_i,
	input wire logic [15:0] req_addr_i,
	input wire logic        req_data_i,
	input wire logic        req_ready_o,
	input wire logic        rd_valid_o,
	input wire logic        rd_data_o,
	input wire logic [15:0] cell_address_o,
	input wire logic        select_n_o,
	input wire logic        write_strobe_n_o,
	input wire logic        data_in_o,
	input wire logic        data_in_oe_o,
	input wire logic        data_out_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rd; req_valid_i && req_ready_o && !req_write_i; endsequence
	sequence s_wr; req_valid_i && req_ready_o && req_write_i; endsequence
	property p_rd_lat; s_rd |-> ##6 rd_valid_o; endproperty
	property p_rd_pulse; rd_valid_o |=> !rd_valid_o; endproperty
	property p_wr_busy; s_wr |=> !req_ready_o [*5] ##1 req_ready_o; endproperty
	property p_addr; $changed(cell_address_o) |->
		(select_n_o || write_strobe_n_o) && ($past(select_n_o) || $past(write_strobe_n_o));
	endproperty
	property p_stb_fall; $fell(write_strobe_n_o) |-> select_n_o; endproperty
	property p_rd_stb; !select_n_o && $past(!select_n_o) |-> $stable(write_strobe_n_o);
	endproperty
	property p_sel_hold; $fell(select_n_o) && !write_strobe_n_o |=> !select_n_o; endproperty
	property p_oe_on; $rose(data_in_oe_o) |-> !write_strobe_n_o && $past(!write_strobe_n_o);
	endproperty
	property p_oe_off; $rose(write_strobe_n_o) |-> !data_in_oe_o; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
	a_wr_busy: assert property (p_wr_busy) else $error("write length wrong");
	a_addr: assert property (p_addr) else $error("address moved in write");
	a_stb_fall: assert property (p_stb_fall) else $error("strobe fell selected");
	a_rd_stb: assert property (p_rd_stb) else $error("strobe moved selected");
	a_sel_hold: assert property (p_sel_hold) else $error("select too short");
	a_oe_on: assert property (p_oe_on) else $error("data driven too early");
	a_oe_off: assert property (p_oe_off) else $error("data driven at close");
endmodule
bind asr_ctrl asr_ctrl_chk i_asr_ctrl_chk (.*);
`default_nettype wire

// *** verif/asr_mem_model.sv ***
// Behavioural model of the 64K by 1 static memory on the far side.
`timescale 1ns/1ns
`default_nettype none
module asr_mem_model (
	input wire logic [15:0] cell_address_i,
	input wire logic        select_n_i,
	input wire logic        write_strobe_n_i,
	input wire logic        data_in_i,
	output var logic        data_out_o
);
	logic mem [65536];
	initial data_out_o = 1'b0;
	// A floating output is shown as the inverse of its last value so it is never trusted.
	always @(select_n_i, write_strobe_n_i, cell_address_i) begin
		if (!select_n_i && write_strobe_n_i) begin
			data_out_o = mem[cell_address_i];
		end else begin
			data_out_o = ~data_out_o;
		end
	end
	always @(posedge select_n_i or posedge write_strobe_n_i) begin
		if (!select_n_i || !write_strobe_n_i) begin
			mem[cell_address_i] = data_in_i;
		end
	end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the static memory controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rv = 1'b0, rw = 1'b0, rd = 1'b0, ok, vld, dat, sn, wn, di, oe, dq;
	logic [15:0] ra = 16'h0000, ca;
	logic q[$];
	logic sm [int];
	int err_total = 0, num_checks = 0, cyc = 0;
	always #25 clk_i = ~clk_i;
	asr_ctrl i_asr_ctrl (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(rv), .req_write_i(rw),
		.req_addr_i(ra), .req_data_i(rd), .req_ready_o(ok), .rd_valid_o(vld), .rd_data_o(dat),
		.cell_address_o(ca), .select_n_o(sn), .write_strobe_n_o(wn), .data_in_o(di),
		.data_in_oe_o(oe), .data_out_i(dq));
	asr_mem_model i_asr_mem_model (.cell_address_i(ca), .select_n_i(sn),
		.write_strobe_n_i(wn), .data_in_i(di), .data_out_o(dq));
	task automatic complete_run;
		if (err_total == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %b got %b", n, e, g);
		end
	endtask
	// Requests are held until ready is seen before the taking edge.
	// Valid stays up between back-to-back calls, so it is never driven twice in one step.
	task automatic req(input logic w, input logic [15:0] a, input logic d);
		rv <= 1'b1;
		rw <= w;
		ra <= a;
		rd <= d;
		do @(negedge clk_i); while (ok !== 1'b1);
		@(posedge clk_i);
		if (w) sm[a] = d;
		else q.push_back(sm[a]);
	endtask
	always @(posedge clk_i) begin
		if (!rst_i && vld === 1'b1) begin
			if (q.size() == 0) chk("unexpected read", 1'b0, 1'b1);
			else chk("rd_data", q.pop_front(), dat);
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		logic [15:0] a;
		logic [15:0] al [40];
		void'($urandom(86));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("select_n idle", 1'b1, sn);
		chk("oe idle", 1'b0, oe);
		@(posedge clk_i);
		foreach (al[i]) begin
			al[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			req(1'b1, al[i], 1'($urandom));
		end
		foreach (al[i]) req(1'b0, al[i], 1'b0);
		foreach (al[i]) begin
			a = al[i];
			req(1'b1, a, ~sm[a]);
			req(1'b0, a, 1'b0);
		end
		rv <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk("answers left", 1'b0, q.size() != 0);
		complete_run();
	end
endmodule
`default_nettype wire
